/* File: hw/pwt_pkg.sv */
/*
 * Shared constants and types for the programmable wait timer.
 * Assumes an 8-bit register port decoded by the serial front end and one
 * clock, clk_sys, on which the wait is counted.
 */
package pwt_pkg;

    // register port and prescaler geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PRE_W  = 16;

    // register addresses
    localparam logic [7:0] ADDR_WAIT_EXTENSION = 8'h0F;
    localparam logic [7:0] ADDR_WAIT_TRIGGER   = 8'h10;

    // values after reset
    localparam logic [7:0] WAIT_EXTENSION_RST = 8'h00;
    localparam logic [7:0] WAIT_TRIGGER_RST   = 8'h00;
    localparam logic [7:0] READ_UNMAPPED      = 8'h00;

    // scaling: base units of 16 cycles, extension units of 256 cycles
    localparam logic [PRE_W-1:0] UNIT_PLAIN_CYCLES = 16'h0010;
    localparam int unsigned      EXT_UNIT_SHIFT    = 8;
    localparam logic [7:0]       EXT_NONE          = 8'h00;
    localparam logic [7:0]       BASE_NOOP         = 8'h00;

    // extreme wait lengths in clock cycles
    localparam logic [23:0] WAIT_MIN_CYCLES = 24'h000010;
    localparam logic [23:0] WAIT_MAX_CYCLES = 24'hFE0100;

    // countdown control, gray coded
    typedef enum logic [0:0] {
        PWT_IDLE = 1'b0,
        PWT_RUN  = 1'b1
    } pwt_state_t;

endpackage

/* File: hw/pwt_wait_counter.sv */
/*
 * Two-level countdown: a prescaler counts out one unit of cycles, the base
 * counter counts units. Total length is base times unit cycles.
 * Assumes load and abort are never high in the same cycle.
 */
`timescale 1ns/1ps
module pwt_wait_counter (
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    // control
    input  wire logic                      load,
    input  wire logic                      abort,
    input  wire logic [7:0]                baseIn,
    input  wire logic [7:0]                extIn,
    // state
    output logic                           running,
    output logic [7:0]                     baseLeft,
    output logic                           expire
);

    pwt_pkg::pwt_state_t            state_r, state_nxt;
    logic [pwt_pkg::PRE_W-1:0]      pre_r, pre_nxt;
    logic [pwt_pkg::PRE_W-1:0]      unit_r, unit_nxt;
    logic [pwt_pkg::PRE_W-1:0]      unitLoad;
    logic [7:0]                     base_r, base_nxt;
    logic                           expire_r, expire_nxt;

    // zero extension means plain 16-cycle units, else ext*16*16 cycles
    always_comb begin
        if (extIn == pwt_pkg::EXT_NONE) begin
            unitLoad = pwt_pkg::UNIT_PLAIN_CYCLES;
        end else begin
            unitLoad = {extIn, 8'h00};
        end
    end

    always_comb begin
        state_nxt  = state_r;
        pre_nxt    = pre_r;
        unit_nxt   = unit_r;
        base_nxt   = base_r;
        expire_nxt = 1'b0;
        case (state_r)
            pwt_pkg::PWT_IDLE: begin
                if (load) begin
                    state_nxt = pwt_pkg::PWT_RUN;
                    unit_nxt  = unitLoad;
                    pre_nxt   = unitLoad - 16'h0001;
                    base_nxt  = baseIn;
                end
            end
            pwt_pkg::PWT_RUN: begin
                if (abort) begin
                    // remaining count is kept for readback
                    state_nxt = pwt_pkg::PWT_IDLE;
                end else if (load) begin
                    unit_nxt = unitLoad;
                    pre_nxt  = unitLoad - 16'h0001;
                    base_nxt = baseIn;
                end else if (pre_r != 16'h0000) begin
                    pre_nxt = pre_r - 16'h0001;
                end else if (base_r == 8'h01) begin
                    base_nxt   = 8'h00;
                    state_nxt  = pwt_pkg::PWT_IDLE;
                    expire_nxt = 1'b1;
                end else begin
                    base_nxt = base_r - 8'h01;
                    pre_nxt  = unit_r - 16'h0001;
                end
            end
            default: begin
                state_nxt = pwt_pkg::PWT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= pwt_pkg::PWT_IDLE;
            pre_r    <= '0;
            unit_r   <= pwt_pkg::UNIT_PLAIN_CYCLES;
            base_r   <= pwt_pkg::WAIT_TRIGGER_RST;
            expire_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            pre_r    <= pre_nxt;
            unit_r   <= unit_nxt;
            base_r   <= base_nxt;
            expire_r <= expire_nxt;
        end
    end

    assign running  = (state_r == pwt_pkg::PWT_RUN);
    assign baseLeft = base_r;
    assign expire   = expire_r;

endmodule

/* File: hw/pwt_wait_timer.sv */
/*
 * Programmable wait timer: extension and trigger registers, countdown,
 * abort on any register write but a non-zero trigger write, done status and wake request.
 * Assumes the serial front end presents each decoded register access as a
 * one-cycle strobe with address and data, synchronous to clk_sys.
 */
`timescale 1ns/1ps
// Summary of operation
// - the wait lasts extension*16 times base*16 clock cycles.
// - an extension of zero gives a wait of base*16 cycles.
// - writing the extension register stores it, starts nothing and aborts a running wait.
// - the extension register reads back its last write and resets to 0.
// - the extension stays for all later waits until it is rewritten or reset.
// - writing a non-zero base to the trigger starts the countdown at once.
// - waits run from 16 cycles up to 255*16*255*16 cycles.
// - reading the trigger register returns the remaining base count.
// - any register write but a non-zero trigger write during a wait aborts it and keeps the count.
// - writing zero to the trigger starts nothing and gives no done status; during a wait it aborts it.
// - a trigger write in sleep or standby asks for normal power state.
module pwt_wait_timer (
    // clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    // register port
    input  wire logic                       regWrEn,
    input  wire logic                       regRdEn,
    input  wire logic [pwt_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [pwt_pkg::DATA_W-1:0] regWrData,
    output logic      [pwt_pkg::DATA_W-1:0] regRdData,
    output logic                            regRdValid,
    // power state
    input  wire logic                       powerStateLow,
    output logic                            powerWakeReq,
    // wait status
    output logic                            waitBusy,
    output logic                            waitDone,
    output logic                            waitDonePulse,
    output logic                            waitAbortPulse
);

    logic [7:0] ext_r, ext_nxt;
    logic [7:0] rdData_r, rdData_nxt;
    logic       rdValid_r, rdValid_nxt;
    logic       done_r, done_nxt;
    logic       abortP_r, abortP_nxt;
    logic       wake_r, wake_nxt;

    logic       wrExt;
    logic       wrTrig;
    logic       startWait;
    logic       abortWait;
    logic       cntRunning;
    logic [7:0] cntLeft;
    logic       cntExpire;

    // address decode of the write strobe
    assign wrExt  = regWrEn && (regAddr == pwt_pkg::ADDR_WAIT_EXTENSION);
    assign wrTrig = regWrEn && (regAddr == pwt_pkg::ADDR_WAIT_TRIGGER);

    // a zero base never reaches the counter
    assign startWait = wrTrig && (regWrData != pwt_pkg::BASE_NOOP);

    // a non-zero trigger write restarts with the new base instead of
    // aborting, so only other writes count as a plain abort
    assign abortWait = regWrEn && !startWait && cntRunning;

    pwt_wait_counter u_counter (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .load     (startWait),
        .abort    (abortWait),
        .baseIn   (regWrData),
        .extIn    (ext_r),
        .running  (cntRunning),
        .baseLeft (cntLeft),
        .expire   (cntExpire)
    );

    // extension register
    always_comb begin
        ext_nxt = ext_r;
        if (wrExt) begin
            ext_nxt = regWrData;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ext_r <= pwt_pkg::WAIT_EXTENSION_RST;
        end else begin
            ext_r <= ext_nxt;
        end
    end

    // read path, one cycle after the strobe
    always_comb begin
        rdValid_nxt = regRdEn;
        rdData_nxt  = rdData_r;
        if (regRdEn) begin
            case (regAddr)
                pwt_pkg::ADDR_WAIT_EXTENSION: begin
                    rdData_nxt = ext_r;
                end
                pwt_pkg::ADDR_WAIT_TRIGGER: begin
                    rdData_nxt = cntLeft;
                end
                default: begin
                    rdData_nxt = pwt_pkg::READ_UNMAPPED;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdData_r  <= pwt_pkg::READ_UNMAPPED;
            rdValid_r <= 1'b0;
        end else begin
            rdData_r  <= rdData_nxt;
            rdValid_r <= rdValid_nxt;
        end
    end

    // done status: sticky until the next start; completion wins over the
    // clear so a finish in the restart cycle is never lost
    always_comb begin
        done_nxt = done_r;
        if (startWait) begin
            done_nxt = 1'b0;
        end
        if (cntExpire) begin
            done_nxt = 1'b1;
        end
    end

    // event pulses for abort and wake-up
    always_comb begin
        abortP_nxt = abortWait;
        wake_nxt   = wrTrig && powerStateLow;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            done_r   <= 1'b0;
            abortP_r <= 1'b0;
            wake_r   <= 1'b0;
        end else begin
            done_r   <= done_nxt;
            abortP_r <= abortP_nxt;
            wake_r   <= wake_nxt;
        end
    end

    // outputs
    assign regRdData      = rdData_r;
    assign regRdValid     = rdValid_r;
    assign powerWakeReq   = wake_r;
    assign waitBusy       = cntRunning;
    assign waitDone       = done_r;
    assign waitDonePulse  = cntExpire;
    assign waitAbortPulse = abortP_r;

endmodule

/* File: sim/pwt_wait_timer_props.sv */
/*
 * Port checker for the wait timer.
 * Assumes one clock, clk_sys, and the active-low asynchronous rst_n.
 */
`timescale 1ns/1ps
module pwt_wait_timer_checker (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_n,
    // register port
    input wire logic       regWrEn,
    input wire logic       regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regRdValid,
    // power and status
    input wire logic       powerStateLow,
    input wire logic       powerWakeReq,
    input wire logic       waitBusy,
    input wire logic       waitDone,
    input wire logic       waitDonePulse,
    input wire logic       waitAbortPulse
);
    logic trg;
    assign trg = regWrEn && regAddr == pwt_pkg::ADDR_WAIT_TRIGGER;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    start_busy_a: assert property (trg && regWrData != 8'h00 |=>
        waitBusy && !waitDone) else $error("start not taken");
    zero_noop_a: assert property (trg && regWrData == 8'h00 && !waitBusy
        |=> !waitBusy && !waitDonePulse) else $error("zero write started");
    ext_idle_a: assert property (regWrEn && !waitBusy &&
        regAddr == pwt_pkg::ADDR_WAIT_EXTENSION |=> !waitBusy)
        else $error("extension write started");
    write_abort_a: assert property (waitBusy && regWrEn && !trg |=>
        !waitBusy && waitAbortPulse && !waitDonePulse)
        else $error("abort missed");
    done_pulse_a: assert property (waitDonePulse |->
        $past(waitBusy) && !waitBusy ##1 waitDone) else $error("bad done");
    done_hold_a: assert property (waitDone && !(trg && regWrData != 8'h00)
        |=> waitDone) else $error("done dropped");
    wake_req_a: assert property (trg && powerStateLow |=> powerWakeReq)
        else $error("no wake request");
    read_ans_a: assert property (regRdEn |=> regRdValid)
        else $error("read unanswered");
    cover property (waitDonePulse);
    cover property (waitAbortPulse);
    cover property (powerWakeReq);
endmodule
bind pwt_wait_timer pwt_wait_timer_checker chk_u (.clk_sys, .rst_n,
    .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdValid, .powerStateLow,
    .powerWakeReq, .waitBusy, .waitDone, .waitDonePulse, .waitAbortPulse);

/* File: sim/pwt_host_model.sv */
/*
 * Host side of the register port: strobed single-byte writes and reads.
 * Assumes the bench calls wr and rd from one process only.
 */
`timescale 1ns/1ps
module pwt_host_model (
    input  wire logic       clk_sys,
    // register port
    output logic            regWrEn,
    output logic            regRdEn,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWrData,
    input  wire logic [7:0] regRdData,
    input  wire logic       regRdValid
);
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end
    // any write may land mid-wait; aborting it is the device's job
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk_sys);
        regWrEn = 1'b0;
        // released lines flip so stale values cannot pass for answers
        regAddr = ~a;
        regWrData = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk_sys);
        regRdEn = 1'b0;
        regAddr = ~a;
        d = regRdValid ? regRdData : 8'hXX;
    endtask
endmodule

/* File: sim/pwt_wait_timer_bench.sv */
/*
 * Self-checking bench for the wait timer, driving through the host model.
 * Assumes inputs change on the falling edge only.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    err_total++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module pwt_wait_timer_bench;
    logic       clk_sys = 1'b0;
    logic       rst_n = 1'b0;
    logic       powerStateLow = 1'b0;
    logic       regWrEn, regRdEn, regRdValid, powerWakeReq;
    logic       waitBusy, waitDone, waitDonePulse, waitAbortPulse;
    logic [7:0] regAddr, regWrData, regRdData, rv;
    int         err_total = 0;
    int         total_checks = 0;
    always #4 clk_sys = ~clk_sys;
    pwt_host_model host_u (.clk_sys, .regWrEn, .regRdEn, .regAddr,
        .regWrData, .regRdData, .regRdValid);
    pwt_wait_timer dut_u (.clk_sys, .rst_n, .regWrEn, .regRdEn, .regAddr,
        .regWrData, .regRdData, .regRdValid, .powerStateLow, .powerWakeReq,
        .waitBusy, .waitDone, .waitDonePulse, .waitAbortPulse);
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // start a wait and count edges from the taking write to busy falling
    task automatic run(input logic [7:0] b, input int cyc);
        int k;
        host_u.wr(pwt_pkg::ADDR_WAIT_TRIGGER, b);
        k = 0;
        while (waitBusy === 1'b1 && k < 70000) begin
            @(negedge clk_sys);
            k++;
        end
        `CHK("wait length", cyc, k)
        `CHK("done pulse", 1'b1, waitDonePulse)
        @(negedge clk_sys);
        `CHK("done pulse end", 1'b0, waitDonePulse)
        `CHK("done flag", 1'b1, waitDone)
        if (k >= 70000) tally_and_finish();
    endtask
    initial begin
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        host_u.rd(8'h0F, rv);
        `CHK("ext reset", 8'h00, rv)
        host_u.rd(8'h10, rv);
        `CHK("count reset", pwt_pkg::WAIT_TRIGGER_RST, rv)
        host_u.rd(8'h20, rv);
        `CHK("unmapped read", pwt_pkg::READ_UNMAPPED, rv)
        run(8'h01, 16);
        run(8'hFF, 4080);
        host_u.wr(8'h0F, 8'h03);
        `CHK("ext no start", 1'b0, waitBusy)
        host_u.rd(8'h0F, rv);
        `CHK("ext read", 8'h03, rv)
        run(8'h02, 1536);
        run(8'h01, 768);
        host_u.wr(8'h0F, 8'h00);
        host_u.wr(8'h10, 8'h05);
        repeat (40) @(negedge clk_sys);
        host_u.rd(8'h10, rv);
        `CHK("count running", 1'b1, rv > 8'h00 && rv < 8'h05)
        host_u.wr(8'h20, 8'hA5);
        `CHK("abort pulse", 1'b1, waitAbortPulse)
        `CHK("abort busy", 1'b0, waitBusy)
        host_u.rd(8'h10, rv);
        `CHK("count kept", 1'b1, rv != 8'h00)
        repeat (100) @(negedge clk_sys);
        `CHK("no done after abort", 1'b0, waitDone)
        powerStateLow = 1'b1;
        host_u.wr(8'h0F, 8'h00);
        `CHK("no wake on ext", 1'b0, powerWakeReq)
        host_u.wr(8'h10, 8'h00);
        `CHK("wake", 1'b1, powerWakeReq)
        `CHK("noop busy", 1'b0, waitBusy)
        repeat (20) @(negedge clk_sys);
        `CHK("noop done", 1'b0, waitDone)
        powerStateLow = 1'b0;
        // reset in mid-wait drops the run and the stored extension
        host_u.wr(pwt_pkg::ADDR_WAIT_EXTENSION, 8'h03);
        host_u.wr(pwt_pkg::ADDR_WAIT_TRIGGER, 8'h02);
        `CHK("busy before reset", 1'b1, waitBusy)
        rst_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        `CHK("reset busy", 1'b0, waitBusy)
        host_u.rd(pwt_pkg::ADDR_WAIT_EXTENSION, rv);
        `CHK("reset ext", pwt_pkg::WAIT_EXTENSION_RST, rv)
        run(8'h01, 16);
        tally_and_finish();
    end
endmodule
